// >>> dv/uart_aux_pin_signalling_bench.sv
// self-checking bench for the auxiliary pin block, with a cycle model
// assumes the bench plays uart core, usb core, straps and storage
`timescale 1ns/10ps
module uart_aux_pin_signalling_bench;
  import uaux_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ext_reset_n = 1'b1;
  logic s0 = 1'b0;
  logic s1 = 1'b0;
  uaux_fn_t fn_a = 2'h0;
  uaux_fn_t fn_b = 2'h0;
  uaux_fn_t fn_c = 2'h0;
  uaux_fn_t fn_d = 2'h0;
  logic susp = 1'b0;
  logic rdy = 1'b0;
  logic req = 1'b0;
  logic tick = 1'b0;
  logic last = 1'b0;
  logic rxb = 1'b0;
  logic irq = 1'b0;
  logic ro = 1'b0;
  logic launch, act, cval, srst_n, hid, pin_c, rxd;
  logic pa_o, pa_e, pb_o, pb_e, pc_o, pc_e, pd_o, pd_e;
  uaux_cfg_t cmode;
  wire logic [9:0] got_pins = {act, hid, pa_o, pa_e, pb_o, pb_e, pc_o, pc_e, pd_o, pd_e};
  wire logic [3:0] got_cfg = {srst_n, cval, cmode};
  int seed = 69;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int mst, nb, dv;
  logic tled, rled, m_act, m_b, m_d, m_hid;
  uaux_fn_t f[4];

  always #2 clk = ~clk;

  uaux_top i_uaux_top (.clk(clk), .rstn(rstn), .ext_reset_n(ext_reset_n), .cfg_select_0(s0),
    .cfg_select_1(s1), .store_fn_a(fn_a), .store_fn_b(fn_b), .store_fn_c(fn_c), .store_fn_d(fn_d),
    .usb_suspend(susp), .usb_ready(rdy), .tx_req(req), .bit_tick(tick), .tx_last(last),
    .rx_busy(rxb), .mux_pin_a_in(pa_e ? pa_o : 1'b1), .mux_pin_b_in(pb_e ? pb_o : 1'b1),
    .mux_pin_c_in(pin_c), .mux_pin_d_in(pd_e ? pd_o : 1'b1), .tx_launch(launch),
    .tx_active(act), .cfg_mode(cmode), .cfg_valid(cval), .sys_rst_n(srst_n),
    .hid_interrupt(hid), .mux_pin_a_out(pa_o), .mux_pin_a_oe(pa_e), .mux_pin_b_out(pb_o),
    .mux_pin_b_oe(pb_e), .mux_pin_c_out(pc_o), .mux_pin_c_oe(pc_e), .mux_pin_d_out(pd_o),
    .mux_pin_d_oe(pd_e));

  uaux_far_side i_uaux_far_side (.irq_req(irq), .c_oe(pc_e), .c_out(pc_o), .tx_active(act),
    .ro(ro), .pin_c(pin_c), .rxd(rxd));

  // ----------------------------------------
  // comparisons and closing
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_pins(input logic [9:0] exp);
    checks_done++;
    if (got_pins !== exp) begin
      fails++;
      $display("wrong value at %0t: pins %b, model %b", $time, got_pins, exp);
    end
  endtask

  task automatic chk_cfg(input logic [3:0] exp);
    checks_done++;
    if (got_cfg !== exp) begin
      fails++;
      $display("wrong value at %0t: reset/config %b, model %b", $time, got_cfg, exp);
    end
  endtask

  task automatic chk_echo(input logic exp);
    checks_done++;
    if (rxd !== exp) begin
      fails++;
      $display("wrong value at %0t: receive %b, model %b", $time, rxd, exp);
    end
  endtask

  task automatic chk_launch(input logic exp);
    checks_done++;
    if (launch !== exp) begin
      fails++;
      $display("wrong value at %0t: launch %b, model %b", $time, launch, exp);
    end
  endtask

  // a hang ends the run as a failure; four tests need about 1240 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      complete_run();
    end
  end

  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic logic [3:0] cfg_of(input logic [1:0] k);
    return {2'h3, (k == 2'h0) ? 2'h0 : (k == 2'h1) ? 2'h1 : 2'h2};
  endfunction

  function automatic logic [9:0] exp_pins();
    logic [1:0] a, b, d;
    a = (f[0] == UAUX_FN_TXACT) ? {m_act, 1'b1} : (f[0] == UAUX_FN_TXLED) ? {tled, 1'b1} : 2'h0;
    b = (f[1] == UAUX_FN_SUSP) ? {m_b, 1'b1} : 2'h0;
    d = (f[3] == UAUX_FN_PWREN) ? {m_d, 1'b1} : (f[3] == UAUX_FN_RXLED) ? {rled, 1'b1} : 2'h0;
    return {m_act, m_hid, a, b, 2'h0, d};
  endfunction

  // advance the model over the edge just passed, with the inputs it saw
  task automatic step();
    tled = m_act ? (tick ? ~tled : tled) : 1'b1;
    rled = rxb ? (tick ? ~rled : rled) : 1'b1;
    m_b = ~susp;
    m_d = ~(rdy & ~susp);
    m_hid = (f[2] == UAUX_FN_INTR) & ~pin_c;
    if (tick) begin
      if (mst == 0 && req) begin
        mst = 1;
      end else if (mst == 1) begin
        mst = 2;
        nb = 0;
      end else if (mst == 2 && last) begin
        mst = 0;
      end else if (mst == 2) begin
        nb++;
      end
    end
    m_act = (mst != 0);
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic start(input logic [1:0] k);
    @(posedge clk);
    #1;
    if (k[0]) ext_reset_n = 1'b0;
    else rstn = 1'b0;
    {req, tick, last, susp, rdy, rxb, irq} = 7'h00;
    {s1, s0} = k;
    {fn_a, fn_b, fn_c, fn_d} = {4{k}};
    #1;
    chk_cfg(4'h0);
    chk_pins(10'h000);
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    ext_reset_n = 1'b1;
    for (int i = 0; i < 10 && cval !== 1'b1; i++) @(posedge clk);
    #1;
    f = '{k, k, k, k};
    {mst, nb, dv} = {32'h0, 32'h0, 32'h0};
    {tled, rled, m_act, m_b, m_d, m_hid} = 6'h36;
    chk_cfg(cfg_of(k));
  endtask

  task automatic run(input int n, input logic [3:0] ecfg);
    int r;
    repeat (n) begin
      @(posedge clk);
      #1;
      step();
      chk_pins(exp_pins());
      chk_cfg(ecfg);
      chk_echo(m_act | ro);
      r = $random(seed);
      {irq, susp, rdy, rxb, req, ro} = r[5:0];
      {fn_a, fn_b, fn_c, fn_d, s0, s1} = r[15:6];
      // one bit period is four clocks
      dv = (dv + 1) % 4;
      tick = (dv == 0);
      last = (mst == 2 && nb == 8);
      #1;
      chk_launch(mst == 1 && tick);
    end
  endtask

  initial begin
    for (int k = 0; k < 4; k++) begin
      start(k[1:0]);
      run(300, cfg_of(k[1:0]));
      $display("test %0d done, mismatches so far %0d", k, fails);
    end
    complete_run();
  end
endmodule

// >>> dv/uaux_far_side.sv
// far side of the pins: hid slave on pin c and an rs485 transceiver
// assumes pin c carries a pull-up and the hid slave only ever pulls low
`timescale 1ns/10ps
module uaux_far_side (
  input wire logic irq_req,
  input wire logic c_oe,
  input wire logic c_out,
  input wire logic tx_active,
  input wire logic ro,
  output logic pin_c,
  output logic rxd
);
  // hid interrupt request
  // open drain: released means the pull-up wins, never the last value
  assign pin_c = irq_req ? 1'b0 : (c_oe ? c_out : 1'b1);
  assign rxd = tx_active | ro;
endmodule

// >>> hdl/uaux_pkg.sv
// constants, function codes and types for the auxiliary pin signalling block
// assumes one system clock; function codes come from configuration storage
package uaux_pkg;

  // pin function codes, as held in configuration storage
  typedef logic [1:0] uaux_fn_t;

  localparam uaux_fn_t UAUX_FN_GPIO = 2'h0;
  localparam uaux_fn_t UAUX_FN_TXACT = 2'h1;
  localparam uaux_fn_t UAUX_FN_TXLED = 2'h2;
  localparam uaux_fn_t UAUX_FN_SUSP = 2'h1;
  localparam uaux_fn_t UAUX_FN_INTR = 2'h1;
  localparam uaux_fn_t UAUX_FN_PWREN = 2'h1;
  localparam uaux_fn_t UAUX_FN_RXLED = 2'h2;

  // functions in force until storage has been captured after reset
  localparam uaux_fn_t UAUX_RST_FN = 2'h0;

  // device interface configuration, one of three
  typedef logic [1:0] uaux_cfg_t;

  localparam uaux_cfg_t UAUX_CFG_0 = 2'h0;
  localparam uaux_cfg_t UAUX_CFG_1 = 2'h1;
  localparam uaux_cfg_t UAUX_CFG_2 = 2'h2;
  localparam uaux_cfg_t UAUX_RST_CFG = 2'h0;

  // idle level of the active-low activity leds (off)
  localparam logic UAUX_LED_OFF = 1'h1;

  // transmit-active sequencer states
  typedef enum logic [1:0] {
    UAUX_TX_IDLE,
    UAUX_TX_LEAD,
    UAUX_TX_SEND
  } uaux_txst_e;

endpackage

// >>> hdl/uaux_top.sv
// auxiliary pin signalling around the uart: reset, config straps, mux pins
// assumes inputs are synchronous to clk; uart core and usb core sit outside
//
// Overview of operation
// - two pulled-down straps choose three configurations
// - reset from external pin or power-on
// - transmit-active rises one bit before start
// - transmit-active falls as stop bit starts
// - transmit-active only while character is sent
// - suspend pin low during usb suspend
// - pin selectable as active-low power enable
// - led pins toggle during transmit, receive
// - pin selectable as hid interrupt input
`timescale 1ns/10ps
module uaux_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ext_reset_n,
  input wire logic cfg_select_0,
  input wire logic cfg_select_1,
  input wire uaux_pkg::uaux_fn_t store_fn_a,
  input wire uaux_pkg::uaux_fn_t store_fn_b,
  input wire uaux_pkg::uaux_fn_t store_fn_c,
  input wire uaux_pkg::uaux_fn_t store_fn_d,
  input wire logic usb_suspend,
  input wire logic usb_ready,
  input wire logic tx_req,
  input wire logic bit_tick,
  input wire logic tx_last,
  input wire logic rx_busy,
  input wire logic mux_pin_a_in,
  input wire logic mux_pin_b_in,
  input wire logic mux_pin_c_in,
  input wire logic mux_pin_d_in,
  output logic tx_launch,
  output logic tx_active,
  output uaux_pkg::uaux_cfg_t cfg_mode,
  output logic cfg_valid,
  output logic sys_rst_n,
  output logic hid_interrupt,
  output logic mux_pin_a_out,
  output logic mux_pin_a_oe,
  output logic mux_pin_b_out,
  output logic mux_pin_b_oe,
  output logic mux_pin_c_out,
  output logic mux_pin_c_oe,
  output logic mux_pin_d_out,
  output logic mux_pin_d_oe
);
  import uaux_pkg::*;

  logic rst_meta_q;
  logic rst_sync_q;
  logic loaded_q;
  uaux_cfg_t cfg_q;
  uaux_fn_t fn_a_q;
  uaux_fn_t fn_b_q;
  uaux_fn_t fn_c_q;
  uaux_fn_t fn_d_q;
  logic transmit_activity_led_q;
  logic receive_activity_led_q;
  logic susp_n_q;
  logic power_enable_n_q;
  logic hid_irq_q;
  logic any_rst_n;
  uaux_tx_if txi ();

  // ----------------------------------------------------------------
  // reset merge
  // ----------------------------------------------------------------
  // either source resets
  // a pin held high, floating-high or pulled high never asserts reset;
  // release is synchronised so all flops leave reset on one edge
  assign any_rst_n = rstn & ext_reset_n;

  always_ff @(posedge clk or negedge any_rst_n) begin
    if (!any_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign sys_rst_n = rst_sync_q;

  // ----------------------------------------------------------------
  // strap and storage capture
  // ----------------------------------------------------------------
  // straps choose configuration
  // functions from storage
  // captured on the first edge after release; both straps high folds
  // onto the third configuration since only three exist
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      loaded_q <= 1'b0;
      cfg_q <= UAUX_RST_CFG;
      fn_a_q <= UAUX_RST_FN;
      fn_b_q <= UAUX_RST_FN;
      fn_c_q <= UAUX_RST_FN;
      fn_d_q <= UAUX_RST_FN;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      case ({cfg_select_1, cfg_select_0})
        2'b00: cfg_q <= UAUX_CFG_0;
        2'b01: cfg_q <= UAUX_CFG_1;
        default: cfg_q <= UAUX_CFG_2;
      endcase
      fn_a_q <= store_fn_a;
      fn_b_q <= store_fn_b;
      fn_c_q <= store_fn_c;
      fn_d_q <= store_fn_d;
    end
  end

  assign cfg_mode = cfg_q;
  assign cfg_valid = loaded_q;

  // ----------------------------------------------------------------
  // transmit-active sequencer
  // ----------------------------------------------------------------
  assign txi.req = tx_req;
  assign txi.tick = bit_tick;
  assign txi.last = tx_last;
  assign tx_launch = txi.launch;
  assign tx_active = txi.active;

  uaux_txact u_txact (
    .clk(clk),
    .rstn(rst_sync_q),
    .txi(txi)
  );

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  // leds toggle on activity
  // toggling per bit keeps the led visibly lit without a long stretcher
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      transmit_activity_led_q <= UAUX_LED_OFF;
    end else if (!txi.active) begin
      transmit_activity_led_q <= UAUX_LED_OFF;
    end else if (bit_tick) begin
      transmit_activity_led_q <= ~transmit_activity_led_q;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      receive_activity_led_q <= UAUX_LED_OFF;
    end else if (!rx_busy) begin
      receive_activity_led_q <= UAUX_LED_OFF;
    end else if (bit_tick) begin
      receive_activity_led_q <= ~receive_activity_led_q;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      susp_n_q <= 1'b1;
    end else begin
      susp_n_q <= ~usb_suspend;
    end
  end

  // power enable low
  // not ready in suspend, so an external receiver is shut off too
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      power_enable_n_q <= 1'b1;
    end else begin
      power_enable_n_q <= ~(usb_ready & ~usb_suspend);
    end
  end

  // hid interrupt input
  // the hid slave pulls the line low while a report is pending
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      hid_irq_q <= 1'b0;
    end else begin
      hid_irq_q <= (fn_c_q == UAUX_FN_INTR) & ~mux_pin_c_in;
    end
  end

  assign hid_interrupt = hid_irq_q;

  // ----------------------------------------------------------------
  // pin multiplexing
  // ----------------------------------------------------------------
  // unselected leaves pin
  // echo gate relies on this being low between characters
  always_comb begin
    mux_pin_a_out = 1'b0;
    mux_pin_a_oe = 1'b0;
    case (fn_a_q)
      UAUX_FN_TXACT: begin
        mux_pin_a_out = txi.active;
        mux_pin_a_oe = 1'b1;
      end
      UAUX_FN_TXLED: begin
        mux_pin_a_out = transmit_activity_led_q;
        mux_pin_a_oe = 1'b1;
      end
      default: begin
        mux_pin_a_out = 1'b0;
        mux_pin_a_oe = 1'b0;
      end
    endcase
  end

  assign mux_pin_b_out = (fn_b_q == UAUX_FN_SUSP) & susp_n_q;
  assign mux_pin_b_oe = (fn_b_q == UAUX_FN_SUSP);

  // input only: an interrupt pin is never driven
  assign mux_pin_c_out = 1'b0;
  assign mux_pin_c_oe = 1'b0;

  always_comb begin
    mux_pin_d_out = 1'b0;
    mux_pin_d_oe = 1'b0;
    case (fn_d_q)
      UAUX_FN_PWREN: begin
        mux_pin_d_out = power_enable_n_q;
        mux_pin_d_oe = 1'b1;
      end
      UAUX_FN_RXLED: begin
        mux_pin_d_out = receive_activity_led_q;
        mux_pin_d_oe = 1'b1;
      end
      default: begin
        mux_pin_d_out = 1'b0;
        mux_pin_d_oe = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rst_hold_a: assert property (@(posedge clk)
    !ext_reset_n |=> !sys_rst_n)
    else $error("external reset did not reach system reset");

  cfg_stable_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    cfg_valid && $past(cfg_valid) |-> $stable(cfg_mode) && cfg_mode != 2'h3)
    else $error("configuration changed after capture");

  cfg_strap_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    !cfg_valid && !cfg_select_0 && !cfg_select_1 |=> cfg_mode == UAUX_CFG_0)
    else $error("low straps did not give first configuration");

  susp_pin_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    fn_b_q == UAUX_FN_SUSP && usb_suspend |=> mux_pin_b_oe && !mux_pin_b_out)
    else $error("suspend pin not low in suspend");

  pwren_pin_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    fn_d_q == UAUX_FN_PWREN && usb_ready && !usb_suspend |=> mux_pin_d_oe && !mux_pin_d_out)
    else $error("power enable not low when ready");

  txled_run_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    txi.active && bit_tick ##1 txi.active |-> transmit_activity_led_q != $past(transmit_activity_led_q))
    else $error("transmit led did not toggle");

  intr_in_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    fn_c_q == UAUX_FN_INTR && !mux_pin_c_in |=> hid_interrupt && !mux_pin_c_oe)
    else $error("hid interrupt not seen");

  txact_pin_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    fn_a_q == UAUX_FN_TXACT |-> mux_pin_a_oe && mux_pin_a_out == tx_active)
    else $error("driver enable pin not following transmit-active");

  gpio_free_a: assert property (@(posedge clk) disable iff (!rst_sync_q)
    fn_a_q == UAUX_FN_GPIO && fn_d_q == UAUX_FN_GPIO |-> !mux_pin_a_oe && !mux_pin_d_oe)
    else $error("unselected function drives its pin");
endmodule

// >>> hdl/uaux_tx_if.sv
// link between the transmit-active sequencer and the uart transmit core
// assumes the core updates its serial output on the clock edge after a tick
`timescale 1ns/10ps
interface uaux_tx_if;
  logic req;
  logic tick;
  logic last;
  logic launch;
  logic active;

  modport act (
    input req,
    input tick,
    input last,
    output launch,
    output active
  );

  modport core (
    output req,
    output tick,
    output last,
    input launch,
    input active
  );
endinterface

// >>> hdl/uaux_txact.sv
// transmit-active sequencer: one bit period of lead, drop with the stop bit
// assumes tick is a one-cycle pulse at each bit boundary of the uart core
`timescale 1ns/10ps
module uaux_txact (
  input wire logic clk,
  input wire logic rstn,
  uaux_tx_if.act txi
);
  import uaux_pkg::*;

  uaux_txst_e st_q;
  logic active_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // lead by one bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= UAUX_TX_IDLE;
    end else begin
      case (st_q)
        UAUX_TX_IDLE: begin
          // entering on a tick makes the lead exactly one bit long
          if (txi.req && txi.tick) begin
            st_q <= UAUX_TX_LEAD;
          end
        end
        UAUX_TX_LEAD: begin
          if (txi.tick) begin
            st_q <= UAUX_TX_SEND;
          end
        end
        UAUX_TX_SEND: begin
          if (txi.tick && txi.last) begin
            st_q <= UAUX_TX_IDLE;
          end
        end
        default: begin
          st_q <= UAUX_TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_q <= 1'b0;
    end else if (st_q == UAUX_TX_IDLE && txi.req && txi.tick) begin
      active_q <= 1'b1;
    end else if (st_q == UAUX_TX_SEND && txi.tick && txi.last) begin
      active_q <= 1'b0;
    end
  end

  // the core drives the start bit on the edge after launch
  assign txi.launch = (st_q == UAUX_TX_LEAD) && txi.tick;
  assign txi.active = active_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_begin;
    st_q == UAUX_TX_IDLE && txi.req && txi.tick;
  endsequence

  sequence s_end;
    st_q == UAUX_TX_SEND && txi.tick && txi.last;
  endsequence

  lead_start_a: assert property (@(posedge clk) disable iff (!rstn)
    s_begin |=> txi.active && !txi.launch)
    else $error("active not raised at character begin");

  launch_lead_a: assert property (@(posedge clk) disable iff (!rstn)
    txi.launch |-> txi.active && $past(txi.active) && txi.tick)
    else $error("start bit launched without one bit of lead");

  stop_drop_a: assert property (@(posedge clk) disable iff (!rstn)
    s_end |=> !txi.active)
    else $error("active not dropped with stop bit");

  only_char_a: assert property (@(posedge clk) disable iff (!rstn)
    txi.active |-> st_q != UAUX_TX_IDLE)
    else $error("active while no character in flight");
endmodule
